// >>> vdc_pkg.sv
// Package: constants for the serial voltage-code control block
package vdc_pkg;
  // Voltage code width and default (mid-scale)
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_RESET = 6'h20;
  // Setpoint map in microvolts: base and step
  localparam int SETPT_MIN_UV = 690000;
  localparam int SETPT_STEP_UV = 21600;
  localparam int SETPT_MAX_UV = 2050000;
  // Setpoint output width (microvolts, fits 2.05 V)
  localparam int SETPT_W = 22;
  // Serial framing
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BITCNT_ZERO = 4'h0;
  // Default slave address; value is arbitrary
  localparam logic [6:0] ADDR_DEFAULT = 7'h2A;
  // Bit of the data byte that disables low-load burst operation
  localparam int BURST_OFF_BIT = 7;
  // Slave transfer states
  typedef enum logic [2:0] {
    VDC_IDLE, VDC_ADDR, VDC_ADDR_ACK, VDC_DATA, VDC_DATA_ACK, VDC_IGNORE
  } vdc_state_t;
endpackage

// >>> vdc_sync.sv
// Two flip-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module vdc_sync
  import vdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q; // First stage, read only by the second

  // Two stages, resting high like an idle bus line
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // vdc_sync
`default_nettype wire

// >>> vdc_setpoint.sv
// Linear map of the voltage code onto a setpoint in microvolts
`timescale 1ns/1ps
`default_nettype none
module vdc_setpoint
  import vdc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Code in, setpoint out
  input wire logic [CODE_W-1:0] code,
  output logic [SETPT_W-1:0] setpointUv
);
  // Registered linear map: base plus code steps
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      setpointUv <= SETPT_W'(SETPT_MIN_UV + int'(CODE_RESET) * SETPT_STEP_UV);
    else
      setpointUv <= SETPT_W'(SETPT_MIN_UV + int'(code) * SETPT_STEP_UV);
  end
endmodule // vdc_setpoint
`default_nettype wire

// >>> vdc_ctrl.sv
// Write-only serial slave that holds the voltage code
`timescale 1ns/1ps
`default_nettype none
module vdc_ctrl
  import vdc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = ADDR_DEFAULT
)
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Run control from the enable pin
  input wire logic runEnable,
  // Serial clock pin, input only
  input wire logic sclIn,
  // Serial data pin, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // Regulator control
  output logic [CODE_W-1:0] voltCode,
  output logic [SETPT_W-1:0] setpointUv,
  output logic useInternalFb,
  output logic burstDisable,
  output logic pulseSkip
);
  logic sclS; // Synchronised clock line
  logic sdaS; // Synchronised data line
  logic runS; // Synchronised enable
  logic sclPrev_q; // Previous clock level
  logic sdaPrev_q; // Previous data level
  logic startEv; // Start condition seen
  logic stopEv; // Stop condition seen
  logic sclRise; // Bit sample edge
  logic sclFall; // Bit shift edge
  logic liveRst; // Reset or shutdown
  vdc_state_t state_q; // Transfer state
  logic [3:0] bitCnt_q; // Bit within segment
  logic [7:0] shift_q; // Incoming byte
  logic [7:0] pend_q; // Pending data byte
  logic pendValid_q; // One data byte held
  logic tooMany_q; // Extra byte seen
  logic ackDrive_q; // Pull SDA low
  logic [CODE_W-1:0] code_q; // Committed code
  logic burstOff_q; // Burst disabled
  logic intFb_q; // Internal feedback latched
  logic commitEv; // Stop closing a clean single-byte write

  // Address byte naming this slave with the write direction
  function automatic logic isOwnWrite(input logic [7:0] b);
    return b == {SLAVE_ADDR, 1'b0};
  endfunction

  // Pin synchronisers
  vdc_sync uSyncScl (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(sclIn),
    .syncOut(sclS));
  vdc_sync uSyncSda (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(sdaIn),
    .syncOut(sdaS));
  vdc_sync uSyncRun (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(runEnable),
    .syncOut(runS));

  // Shutdown resets the interface like a reset
  assign liveRst = !rst_n || !runS;

  // Edge history; 20 MHz sampling covers fast bus speed
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // Bus conditions from synchronised levels
  assign startEv = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  assign stopEv = sclS && sclPrev_q && !sdaPrev_q && sdaS;
  assign sclRise = sclS && !sclPrev_q;
  assign sclFall = !sclS && sclPrev_q;
  // Commit point: stop after exactly one data byte
  assign commitEv = stopEv && pendValid_q && !tooMany_q;

  // Transfer state machine, 9-bit segments
  always_ff @(posedge ref_clk)
  begin
    if (liveRst)
      state_q <= VDC_IDLE;
    else if (startEv)
      state_q <= VDC_ADDR; // Repeated start restarts framing
    else if (stopEv)
      state_q <= VDC_IDLE;
    else if (sclFall)
    begin
      case (state_q)
        VDC_ADDR:
          if (bitCnt_q == ACK_SLOT)
          begin
            // Own address with write direction only
            if (isOwnWrite(shift_q))
              state_q <= VDC_ADDR_ACK;
            else
              state_q <= VDC_IGNORE;
          end
        VDC_ADDR_ACK:
          state_q <= VDC_DATA;
        VDC_DATA:
          if (bitCnt_q == ACK_SLOT)
            state_q <= VDC_DATA_ACK;
        VDC_DATA_ACK:
          state_q <= VDC_DATA;
        default:
          state_q <= state_q;
      endcase
    end
  end

  // Bit counter and shift register, sampled on clock rise
  always_ff @(posedge ref_clk)
  begin
    if (liveRst || startEv)
    begin
      bitCnt_q <= BITCNT_ZERO;
      shift_q <= 8'h00;
    end
    else if (sclRise && bitCnt_q <= LAST_BIT &&
             (state_q == VDC_ADDR || state_q == VDC_DATA))
    begin
      shift_q <= {shift_q[6:0], sdaS};
      bitCnt_q <= bitCnt_q + 4'h1;
    end
    else if (sclFall && bitCnt_q == ACK_SLOT)
      bitCnt_q <= BITCNT_ZERO;
    else if (sclFall && bitCnt_q == LAST_BIT + 4'h1 &&
             state_q != VDC_ADDR && state_q != VDC_DATA)
      bitCnt_q <= BITCNT_ZERO;
  end

  // Ack drive: low from falling edge into slot to next fall
  always_ff @(posedge ref_clk)
  begin
    if (liveRst || startEv || stopEv)
      ackDrive_q <= 1'b0;
    else if (sclFall && bitCnt_q == ACK_SLOT &&
             state_q == VDC_ADDR && isOwnWrite(shift_q))
      ackDrive_q <= 1'b1; // Address matched
    else if (sclFall && bitCnt_q == ACK_SLOT && state_q == VDC_DATA)
      ackDrive_q <= 1'b1; // Every data byte acknowledged
    else if (sclFall)
      ackDrive_q <= 1'b0; // Release after the ack pulse
  end

  // Pending data byte; extra bytes spoil the single-byte write
  always_ff @(posedge ref_clk)
  begin
    if (liveRst || startEv)
    begin
      pend_q <= 8'h00;
      pendValid_q <= 1'b0;
      tooMany_q <= 1'b0;
    end
    else if (sclFall && bitCnt_q == ACK_SLOT && state_q == VDC_DATA)
    begin
      pend_q <= shift_q;
      pendValid_q <= 1'b1;
      tooMany_q <= pendValid_q;
    end
    else if (stopEv)
      pendValid_q <= 1'b0;
  end

  // Commit on valid stop only
  always_ff @(posedge ref_clk)
  begin
    if (liveRst)
    begin
      code_q <= CODE_RESET;
      burstOff_q <= 1'b0;
    end
    else if (commitEv)
    begin
      code_q <= pend_q[CODE_W-1:0];
      burstOff_q <= pend_q[BURST_OFF_BIT];
    end
  end

  // Feedback hand-over, held until reset or disable
  always_ff @(posedge ref_clk)
  begin
    if (liveRst)
      intFb_q <= 1'b0;
    else if (commitEv)
      intFb_q <= 1'b1;
  end

  // Setpoint map from committed code
  vdc_setpoint uMap (.ref_clk(ref_clk), .rst_n(!liveRst), .code(code_q),
    .setpointUv(setpointUv));

  // Outputs; SCL has no driver at all
  assign sdaOut = 1'b0; // Only ever pulls low
  assign sdaOe_n = !ackDrive_q; // Released otherwise
  assign voltCode = code_q;
  assign useInternalFb = intFb_q;
  assign burstDisable = burstOff_q;
  assign pulseSkip = burstOff_q;

  // Code returns to default one cycle after reset or shutdown
  AST_CODE_DEFAULT: assert property (@(posedge ref_clk)
    liveRst |=> voltCode == CODE_RESET)
    else $error("code not at default after reset");

  // Code only changes on a stop
  AST_CODE_ON_STOP: assert property (@(posedge ref_clk)
    disable iff (liveRst) $changed(voltCode) |-> $past(stopEv))
    else $error("code changed without stop");

  // Internal feedback never drops while enabled
  AST_FB_STICKY: assert property (@(posedge ref_clk)
    disable iff (liveRst) $fell(useInternalFb) |-> 1'b0)
    else $error("internal feedback released while enabled");

  // Feedback hand-over only follows a stop
  AST_FB_ON_STOP: assert property (@(posedge ref_clk)
    disable iff (liveRst) $rose(useInternalFb) |-> $past(stopEv))
    else $error("hand-over without stop");

  // Ack held low while clock high
  sequence seqAckHigh;
    !sdaOe_n && sclS;
  endsequence
  AST_ACK_STEADY: assert property (@(posedge ref_clk)
    disable iff (liveRst) seqAckHigh ##1 sclS |-> !sdaOe_n)
    else $error("ack released in clock high");

  // Data line driven only low
  AST_DRIVE_LOW: assert property (@(posedge ref_clk)
    !sdaOe_n |-> !sdaOut)
    else $error("data driven high");

  // Ack only in the ninth slot after a byte
  AST_ACK_SLOT: assert property (@(posedge ref_clk)
    disable iff (liveRst)
    $fell(sdaOe_n) |-> $past(sclFall) && $past(bitCnt_q) == ACK_SLOT)
    else $error("ack outside slot");

  // Foreign address never acknowledged
  AST_NO_FOREIGN_ACK: assert property (@(posedge ref_clk)
    disable iff (liveRst) state_q == VDC_IGNORE |-> sdaOe_n)
    else $error("ack while ignoring");

  // Ignored frame stays ignored until a start or stop
  AST_IGNORE_HOLDS: assert property (@(posedge ref_clk)
    disable iff (liveRst)
    state_q == VDC_IGNORE && !startEv && !stopEv |=> state_q == VDC_IGNORE)
    else $error("ignored frame resumed");

  // Stop returns the slave to idle within one cycle
  AST_STOP_IDLE: assert property (@(posedge ref_clk)
    disable iff (liveRst)
    stopEv && !startEv |=> state_q == VDC_IDLE && sdaOe_n)
    else $error("bus not freed by stop");

  // Start begins address framing
  AST_START_FRAME: assert property (@(posedge ref_clk)
    disable iff (liveRst)
    startEv |=> state_q == VDC_ADDR && bitCnt_q == BITCNT_ZERO)
    else $error("start not framed");

  // Start throws away any pending data byte
  AST_START_DROPS: assert property (@(posedge ref_clk)
    disable iff (liveRst) startEv |=> !pendValid_q)
    else $error("pending data kept over start");

  // A write with an extra byte leaves the code alone
  AST_EXTRA_NO_COMMIT: assert property (@(posedge ref_clk)
    disable iff (liveRst) stopEv && tooMany_q |=> $stable(voltCode))
    else $error("multi-byte write committed");
endmodule // vdc_ctrl
`default_nettype wire

// >>> vdc_master_model.sv
// Behavioural two-wire bus master driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module vdc_master_model
  import vdc_pkg::*;
(
  // Clock and speed select
  input wire logic ref_clk,
  input wire logic fastMode,
  // Master lines, released means high
  output logic sclLine,
  output logic sdaRel,
  // Resolved data wire
  input wire logic sdaWire
);
  // Both lines released while idle
  initial
  begin
    sclLine = 1'b1;
    sdaRel = 1'b1;
  end
  // Half bus phase: 1 us fast, 5 us standard; off the edge
  localparam int HP_FAST = 20;
  localparam int HP_STD = 100;
  task automatic hp();
    repeat (fastMode ? HP_FAST : HP_STD) @(posedge ref_clk);
    #1;
  endtask
  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    sdaRel = 1'b1;
    hp();
    sclLine = 1'b1;
    hp();
    sdaRel = 1'b0;
    hp();
    sclLine = 1'b0;
    hp();
  endtask
  // Stop: SDA rises while SCL high
  task automatic stop();
    sdaRel = 1'b0;
    hp();
    sclLine = 1'b1;
    hp();
    sdaRel = 1'b1;
    hp();
  endtask
  // Byte MSB first, then ack slot with SDA released
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaRel = b[i];
      hp();
      sclLine = 1'b1;
      hp();
      sclLine = 1'b0;
      hp();
    end
    sdaRel = 1'b1;
    hp();
    sclLine = 1'b1;
    @(posedge ref_clk);
    #1;
    // Ack must be low early and late in the high phase
    ack = ~sdaWire;
    hp();
    ack = ack & ~sdaWire;
    sclLine = 1'b0;
    hp();
  endtask
endmodule // vdc_master_model
`default_nettype wire

// >>> test_i2c_write_only_voltage_dac_control.sv
// Self-checking bench for the serial voltage-code slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errTotal++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_i2c_write_only_voltage_dac_control
  import vdc_pkg::*;
;
  // Clock, reset, enable and bus lines
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic runEnable = 1'b1;
  logic fastMode = 1'b1;
  logic sclLine;
  logic sdaRel;
  wire logic sdaWire;
  logic sdaOut;
  logic sdaOe_n;
  // Regulator control outputs
  logic [CODE_W-1:0] voltCode;
  logic [SETPT_W-1:0] setpointUv;
  logic useInternalFb;
  logic burstDisable;
  logic pulseSkip;
  // Expected state, scratch and counters
  logic [5:0] expCode = CODE_RESET;
  logic expBurst = 1'b0;
  logic expFb = 1'b0;
  logic [7:0] d;
  logic ackA;
  logic ackD;
  int errTotal = 0;
  int nTests = 0;
  int cyc = 0;
  // Open-drain data wire with pull-up
  assign sdaWire = sdaRel & (sdaOe_n | sdaOut);
  // Clock of 50 ns period
  always #25 ref_clk = ~ref_clk;
  // Device under test
  vdc_ctrl #(.SLAVE_ADDR(ADDR_DEFAULT)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .runEnable(runEnable),
    .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .voltCode(voltCode), .setpointUv(setpointUv),
    .useInternalFb(useInternalFb), .burstDisable(burstDisable),
    .pulseSkip(pulseSkip));
  // Bus master
  vdc_master_model m (.ref_clk(ref_clk), .fastMode(fastMode),
    .sclLine(sclLine),
    .sdaRel(sdaRel), .sdaWire(sdaWire));
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errTotal++;
      reportAndStop();
    end
  end
  // Expected setpoint in microvolts
  function automatic logic [SETPT_W-1:0] expSet(input logic [5:0] c);
    return SETPT_W'(SETPT_MIN_UV + int'(c) * SETPT_STEP_UV);
  endfunction
  // Closing report
  task automatic reportAndStop();
    $display("errors %0d of %0d compares", errTotal, nTests);
    if (errTotal == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Wait clocks, then step off the edge
  task automatic waitClk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Compare outputs with the expected state
  task automatic chkState();
    `CHK(voltCode, expCode)
    `CHK(setpointUv, expSet(expCode))
    `CHK(burstDisable, expBurst)
    `CHK(pulseSkip, expBurst)
    `CHK(useInternalFb, expFb)
    `CHK(sdaOe_n, 1'b1)
  endtask
  // Expect the default code and external feedback
  task automatic chkDefault();
    expCode = CODE_RESET;
    expBurst = 1'b0;
    expFb = 1'b0;
    chkState();
  endtask
  // Full write: address, one data byte, stop
  task automatic goodWrite(input logic [7:0] v);
    m.start();
    m.sendByte({ADDR_DEFAULT, 1'b0}, ackA);
    `CHK(ackA, 1'b1)
    m.sendByte(v, ackD);
    `CHK(ackD, 1'b1)
    waitClk(8);
    chkState();
    m.stop();
    waitClk(8);
    expCode = v[5:0];
    expBurst = v[7];
    expFb = 1'b1;
    chkState();
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'hBA02D38B));
    waitClk(5);
    rst_n = 1'b1;
    waitClk(4);
    chkDefault();
    // Corner codes first, then random bytes
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 0) ? 8'h3F : (i == 1) ? 8'h00 : 8'($urandom);
      goodWrite(d);
    end
    // Two writes at standard bus speed
    fastMode = 1'b0;
    goodWrite(8'($urandom));
    goodWrite(8'hAB);
    fastMode = 1'b1;
    // Shutdown restores default and external feedback
    runEnable = 1'b0;
    waitClk(5);
    runEnable = 1'b1;
    waitClk(4);
    chkDefault();
    // Refused writes must not hand over control
    // Foreign address and read direction are not acknowledged
    for (int j = 0; j < 2; j++)
    begin
      d = (j == 0) ? {ADDR_DEFAULT ^ 7'h01, 1'b0} : {ADDR_DEFAULT, 1'b1};
      m.start();
      m.sendByte(d, ackA);
      `CHK(ackA, 1'b0)
      m.stop();
      waitClk(8);
      chkState();
    end
    // Two data bytes, then a write cut by a repeated start
    for (int k = 0; k < 2; k++)
    begin
      m.start();
      m.sendByte({ADDR_DEFAULT, 1'b0}, ackA);
      m.sendByte(8'h05, ackD);
      if (k == 0)
        m.sendByte(8'h06, ackD);
      else
        m.start();
      `CHK(ackD, 1'b1)
      m.stop();
      waitClk(8);
      chkState();
    end
    // Valid write hands control to the internal code
    goodWrite(8'h91);
    // Reset in mid-run restores the default
    rst_n = 1'b0;
    waitClk(5);
    rst_n = 1'b1;
    waitClk(4);
    chkDefault();
    reportAndStop();
  end
endmodule // test_i2c_write_only_voltage_dac_control
`default_nettype wire
